// File: include/usart_map.svh
// Constants for the USART transmit and receive data path.
// Included by the data path file; holds definitions only.
`ifndef USART_MAP_SVH
`define USART_MAP_SVH

// Sample ticks per bit in asynchronous mode
`define TICKS_PER_BIT     16
// Tick index where a start bit is checked again (mid bit)
`define START_CHECK_TICK  4'h7
// Last tick of a bit period
`define LAST_TICK         4'hF
// Character size code that selects nine data bits
`define CHAR_SIZE_NINE    3'h7
// Default depths and widths
`define DEFAULT_FIFO_DEPTH 32
`define DEFAULT_RX_DEPTH   2
`define DEFAULT_DIV_WIDTH  12
// Reset level of the serial line (idle high)
`define LINE_IDLE         1'b1

`endif

// File: include/usart_pkg.sv
// Types shared by the USART data path.
// Assumes no other package; constants live in usart_map.svh.
package usart_pkg;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;

  // Frame format and mode, shared by both directions
  typedef struct packed {
    logic       sync_mode;
    logic       clock_polarity;
    logic [2:0] char_size_field;
    logic       parity_enable_bit;
    logic       parity_odd;
    logic       two_stop;
  } frame_cfg_s;

  // One received character with its status
  typedef struct packed {
    logic       overrun;
    logic       frame_error;
    logic       parity_error;
    logic [8:0] data;
  } rx_word_s;

endpackage

// File: src/usart_tx_rx_datapath.sv
// USART transmit and receive data path with receive FIFO.
// Assumes control bits come from flops on clk; serial pins are asynchronous.
// Notes on behaviour
// - Transmitter enable takes over the output pin
// - Sync mode transmits on external clock edges
// - Data write fills buffer and starts sending
// - Buffer loads shifter when idle or after stop
// - Short characters drop upper written bits
// - Ninth bit comes from ninth-bit control
// - Empty flag shows transmit buffer state
// - Data write clears the empty flag
// - Empty interrupt requested while flag and enable
// - Complete flag sets when frame out, buffer empty
// - Complete flag cleared by service or write-one
// - Complete interrupt requested when flag sets
// - Parity bit sent between data and stop
// - Disable waits for shifter and buffer empty
// - Receiver enable takes over the input pin
// - Sync mode samples on external clock edges
// - Reception starts on valid start bit only
// - Second stop bit is ignored
// - First stop bit moves frame to buffer
// - Short received characters read upper zeros
// - Receive flag shows unread characters exist
// - Two-deep buffer, overrun on further start
`timescale 1ns/1ps
`include "usart_map.svh"

module usart_fifo
  import usart_pkg::*;
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = `DEFAULT_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 1 || WIDTH < 1) begin : g_check
    $error("usart_fifo: DEPTH and WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // Handshakes; full refuses the source
  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_r];

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and fill level, wrapping at DEPTH
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  property p_full_holds;
    @(posedge clk) disable iff (!reset_n)
    (count_r == (AW+1)'(DEPTH) && !out_ready && !flush) |=> !in_ready;
  endproperty
  a_full_holds: assert property (p_full_holds)
    else $error("fifo accepted data while full");
endmodule

module usart_tx_rx_datapath
  import usart_pkg::*;
#(
  parameter int DIV_WIDTH = `DEFAULT_DIV_WIDTH,
  parameter int RX_DEPTH  = `DEFAULT_RX_DEPTH
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire frame_cfg_s           frame_cfg,
  input  wire logic [DIV_WIDTH-1:0] baud_divisor,
  input  wire logic                 transmitter_enable,
  input  wire logic                 receiver_enable,
  input  wire logic                 transmit_ninth_bit,
  input  wire logic                 buffer_empty_irq_enable,
  input  wire logic                 transmit_complete_irq_enable,
  input  wire logic                 data_wr,
  input  wire logic [7:0]           data_wdata,
  input  wire logic                 data_rd,
  input  wire logic                 txc_clear,
  input  wire logic                 txc_irq_ack,
  input  wire logic                 serial_in_pin,
  input  wire logic                 serial_clock_pin,
  output logic                      serial_out_pin_o,
  output logic                      serial_out_pin_oe,
  output logic                      serial_in_owned,
  output logic                      buffer_empty_flag,
  output logic                      transmit_complete_flag,
  output logic                      receive_complete_flag,
  output rx_word_s                  rx_word,
  output logic                      buffer_empty_irq,
  output logic                      transmit_complete_irq
);
  if (DIV_WIDTH < 1 || RX_DEPTH < 2) begin : g_check
    $error("usart: DIV_WIDTH >= 1 and RX_DEPTH >= 2 required");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Data bits per character from the size code
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    unique case (code)
      3'h0:            char_bits = 4'h5;
      3'h1:            char_bits = 4'h6;
      3'h2:            char_bits = 4'h7;
      `CHAR_SIZE_NINE: char_bits = 4'h9;
      default:         char_bits = 4'h8;
    endcase
  endfunction

  logic [3:0]           nbits;
  logic [8:0]           char_mask;
  logic                 rxd_s1_r, rxd_s2_r;
  logic                 xck_s1_r, xck_s2_r, xck_s3_r;
  logic                 xck_rise, change_edge, samp_edge;
  logic [DIV_WIDTH-1:0] baud_cnt_r;
  logic                 tick;

  assign nbits     = char_bits(frame_cfg.char_size_field);
  assign char_mask = ~(9'h1FF << nbits);

  // Two-stage synchronisers; edge detect reads only later stages
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxd_s1_r <= `LINE_IDLE;
      rxd_s2_r <= `LINE_IDLE;
      xck_s1_r <= 1'b0;
      xck_s2_r <= 1'b0;
      xck_s3_r <= 1'b0;
    end else begin
      rxd_s1_r <= serial_in_pin;
      rxd_s2_r <= rxd_s1_r;
      xck_s1_r <= serial_clock_pin;
      xck_s2_r <= xck_s1_r;
      xck_s3_r <= xck_s2_r;
    end
  end

  // Data changes on one external edge and is sampled on the other
  assign xck_rise    = xck_s2_r && !xck_s3_r;
  assign change_edge = frame_cfg.clock_polarity ? (xck_s3_r && !xck_s2_r) : xck_rise;
  assign samp_edge   = frame_cfg.clock_polarity ? xck_rise : (xck_s3_r && !xck_s2_r);

  // Baud divider gives one tick per sixteenth of a bit
  assign tick = (baud_cnt_r == baud_divisor);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      baud_cnt_r <= '0;
    end else begin
      baud_cnt_r <= tick ? '0 : baud_cnt_r + 1'b1;
    end
  end

  // ---------------- transmitter ----------------
  tx_state_e  tx_state_r;
  logic       buf_full_r;
  logic [8:0] buf_data_r;
  logic [8:0] tx_sh_r;
  logic [3:0] tx_cnt_r;
  logic [3:0] tx_tcnt_r;
  logic       tx_par_r;
  logic       tx_stop2_r;
  logic       tx_line_r;
  logic       tx_own_r;
  logic       txc_r;
  logic       tx_step, tx_last_stop, tx_load, txc_set;
  logic [8:0] tx_char;

  assign tx_step      = frame_cfg.sync_mode ? change_edge : (tick && tx_tcnt_r == `LAST_TICK);
  assign tx_last_stop = (tx_state_r == TX_STOP) && tx_step && (!frame_cfg.two_stop || tx_stop2_r);
  assign tx_load      = buf_full_r && tx_own_r && (tx_state_r == TX_IDLE || tx_last_stop);
  assign txc_set      = tx_last_stop && !buf_full_r;
  assign tx_char      = buf_data_r & char_mask;

  // Single transmit buffer; a write overwrites an unsent character
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_full_r <= 1'b0;
      buf_data_r <= '0;
    end else if (data_wr) begin
      buf_full_r <= 1'b1;
      buf_data_r <= {transmit_ninth_bit, data_wdata};
    end else if (tx_load) begin
      buf_full_r <= 1'b0;
    end
  end

  // Pin ownership is kept until both buffer and shifter drain
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_own_r <= 1'b0;
    end else if (transmitter_enable) begin
      tx_own_r <= 1'b1;
    end else if (tx_state_r == TX_IDLE && !buf_full_r) begin
      tx_own_r <= 1'b0;
    end
  end

  // Frame sequencer: start, data LSB first, parity, stop bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_r <= TX_IDLE;
      tx_sh_r    <= '0;
      tx_cnt_r   <= '0;
      tx_tcnt_r  <= '0;
      tx_par_r   <= 1'b0;
      tx_stop2_r <= 1'b0;
      tx_line_r  <= `LINE_IDLE;
    end else if (tx_load) begin
      tx_state_r <= TX_START;
      tx_sh_r    <= tx_char;
      tx_par_r   <= (^tx_char) ^ frame_cfg.parity_odd;
      tx_tcnt_r  <= '0;
      tx_stop2_r <= 1'b0;
      tx_line_r  <= 1'b0;
    end else begin
      tx_tcnt_r <= (tx_state_r == TX_IDLE) ? '0 : tx_tcnt_r + 4'(tick);
      if (tx_step) begin
        unique case (tx_state_r)
          TX_IDLE: tx_line_r <= `LINE_IDLE;
          TX_START: begin
            tx_state_r <= TX_DATA;
            tx_line_r  <= tx_sh_r[0];
            tx_sh_r    <= tx_sh_r >> 1;
            tx_cnt_r   <= 4'h1;
          end
          TX_DATA: begin
            if (tx_cnt_r == nbits) begin
              tx_state_r <= frame_cfg.parity_enable_bit ? TX_PAR : TX_STOP;
              tx_line_r  <= frame_cfg.parity_enable_bit ? tx_par_r : `LINE_IDLE;
            end else begin
              tx_line_r <= tx_sh_r[0];
              tx_sh_r   <= tx_sh_r >> 1;
              tx_cnt_r  <= tx_cnt_r + 4'h1;
            end
          end
          TX_PAR: begin
            tx_state_r <= TX_STOP;
            tx_line_r  <= `LINE_IDLE;
          end
          TX_STOP: begin
            tx_stop2_r <= 1'b1;
            if (tx_last_stop) begin
              tx_state_r <= TX_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Transmit complete; a new set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txc_r <= 1'b0;
    end else if (txc_set) begin
      txc_r <= 1'b1;
    end else if (txc_clear || txc_irq_ack) begin
      txc_r <= 1'b0;
    end
  end

  // Pin and flag outputs
  assign serial_out_pin_o       = tx_line_r;
  assign serial_out_pin_oe      = tx_own_r;
  assign buffer_empty_flag      = !buf_full_r;
  assign transmit_complete_flag = txc_r;
  assign buffer_empty_irq       = buffer_empty_irq_enable && !buf_full_r;
  assign transmit_complete_irq  = transmit_complete_irq_enable && txc_r;

  // ---------------- receiver ----------------
  rx_state_e  rx_state_r;
  logic [8:0] rx_sh_r;
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_tcnt_r;
  logic       rx_par_r;
  logic       pend_valid_r;
  rx_word_s   pend_word_r;
  rx_word_s   fifo_in;
  logic       dor_r;
  logic       fifo_ready;
  logic       rx_samp, rx_start_seen;

  assign serial_in_owned = receiver_enable;
  assign rx_samp       = frame_cfg.sync_mode ? samp_edge : (tick && rx_tcnt_r == `LAST_TICK);
  assign rx_start_seen = (rx_state_r == RX_IDLE) && !rxd_s2_r && (!frame_cfg.sync_mode || samp_edge);

  // Frame receiver; only the first stop bit is looked at
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_r  <= RX_IDLE;
      rx_sh_r     <= '0;
      rx_cnt_r    <= '0;
      rx_tcnt_r   <= '0;
      rx_par_r    <= 1'b0;
      pend_word_r <= '0;
    end else if (!receiver_enable) begin
      rx_state_r <= RX_IDLE;
    end else begin
      rx_tcnt_r <= rx_tcnt_r + 4'(tick);
      unique case (rx_state_r)
        RX_IDLE: begin
          rx_tcnt_r <= '0;
          rx_cnt_r  <= '0;
          rx_par_r  <= 1'b0;
          if (rx_start_seen) begin
            rx_state_r <= frame_cfg.sync_mode ? RX_DATA : RX_START;
          end
        end
        RX_START: begin
          if (tick && rx_tcnt_r == `START_CHECK_TICK) begin
            rx_tcnt_r  <= '0;
            rx_state_r <= rxd_s2_r ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_samp) begin
            rx_sh_r  <= {rxd_s2_r, rx_sh_r[8:1]};
            rx_par_r <= rx_par_r ^ rxd_s2_r;
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == nbits - 4'h1) begin
              rx_state_r <= frame_cfg.parity_enable_bit ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_samp) begin
            rx_par_r   <= rx_par_r ^ rxd_s2_r ^ frame_cfg.parity_odd;
            rx_state_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_samp) begin
            pend_word_r.overrun      <= 1'b0;
            pend_word_r.frame_error  <= !rxd_s2_r;
            pend_word_r.parity_error <= frame_cfg.parity_enable_bit && rx_par_r;
            pend_word_r.data         <= rx_sh_r >> (4'h9 - nbits);
            rx_state_r               <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Completed frame waits here while the buffer is full
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_valid_r <= 1'b0;
    end else if (!receiver_enable) begin
      pend_valid_r <= 1'b0;
    end else if (rx_state_r == RX_STOP && rx_samp) begin
      pend_valid_r <= 1'b1;
    end else if (fifo_ready) begin
      pend_valid_r <= 1'b0;
    end
  end

  // Overrun: buffer full, frame waiting, new start bit; set wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dor_r <= 1'b0;
    end else if (!receiver_enable) begin
      dor_r <= 1'b0;
    end else if (rx_start_seen && pend_valid_r && !fifo_ready) begin
      dor_r <= 1'b1;
    end else if (pend_valid_r && fifo_ready) begin
      dor_r <= 1'b0;
    end
  end

  // Overrun travels with the next character stored
  always_comb begin
    fifo_in         = pend_word_r;
    fifo_in.overrun = dor_r;
  end

  usart_fifo #(
    .WIDTH ($bits(rx_word_s)),
    .DEPTH (RX_DEPTH)
  ) u_rx_buf (
    .clk       (clk),
    .reset_n   (reset_n),
    .flush     (!receiver_enable),
    .in_valid  (pend_valid_r),
    .in_ready  (fifo_ready),
    .in_data   (fifo_in),
    .out_valid (receive_complete_flag),
    .out_ready (data_rd),
    .out_data  (rx_word)
  );

  // ---------------- checks ----------------
  sequence s_tx_load;
    tx_state_r == TX_IDLE && tx_load;
  endsequence

  property p_pin_owned;
    transmitter_enable |=> serial_out_pin_oe;
  endproperty
  a_pin_owned: assert property (p_pin_owned)
    else $error("transmit pin not taken over");

  property p_start_bit;
    s_tx_load |=> !serial_out_pin_o && tx_state_r == TX_START;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("start bit not driven after load");

  property p_write_clears;
    data_wr |=> !buffer_empty_flag;
  endproperty
  a_write_clears: assert property (p_write_clears)
    else $error("write did not clear empty flag");

  property p_empty_irq;
    buffer_empty_irq && !data_wr |=> buffer_empty_flag ##0 (buffer_empty_irq == buffer_empty_irq_enable);
  endproperty
  a_empty_irq: assert property (p_empty_irq)
    else $error("empty interrupt request dropped without a write");

  property p_txc_set;
    txc_set |=> transmit_complete_flag ##0 (transmit_complete_irq == transmit_complete_irq_enable);
  endproperty
  a_txc_set: assert property (p_txc_set)
    else $error("complete flag not set after frame");

  property p_txc_clear;
    (txc_clear || txc_irq_ack) && !txc_set |=> !transmit_complete_flag;
  endproperty
  a_txc_clear: assert property (p_txc_clear)
    else $error("complete flag not cleared");

  property p_hold_pin;
    tx_own_r && (buf_full_r || tx_state_r != TX_IDLE) |=> serial_out_pin_oe;
  endproperty
  a_hold_pin: assert property (p_hold_pin)
    else $error("pin released with data pending");

  property p_stop_store;
    rx_state_r == RX_STOP && rx_samp && receiver_enable |=> pend_valid_r ##1 (pend_valid_r || receive_complete_flag);
  endproperty
  a_stop_store: assert property (p_stop_store)
    else $error("received frame not stored");

  property p_flush;
    !receiver_enable |=> !receive_complete_flag && !pend_valid_r;
  endproperty
  a_flush: assert property (p_flush)
    else $error("receive buffer not flushed");
endmodule

// File: verification/usart_partner_model.sv
// Remote serial transceiver facing the data path pins.
// Assumes one bit lasts BIT clocks of clk and the line idles high.
`timescale 1ns/1ps

module usart_partner_model #(
  parameter int BIT = 16
) (
  input  wire logic       clk,
  input  wire logic       line_in,
  input  wire logic [3:0] nbits,
  input  wire logic       par_en,
  output logic            line_out
);
  logic [9:0] got_q[$];
  logic [9:0] w;

  // Line towards the design idles high
  initial begin
    line_out = 1'b1;
  end

  // Send one frame LSB first; stop_lvl low breaks the first stop bit
  task automatic send(input logic [8:0] d, input logic par, input logic stop_lvl);
    int n;
    logic b;
    begin
      n = nbits + par_en + 1;
      for (int i = 0; i <= n; i++) begin
        b = (i == 0) ? 1'b0 : (i <= nbits) ? d[i-1] : (i < n) ? par : stop_lvl;
        @(posedge clk);
        #1 line_out = b;
        repeat (BIT - 1) @(posedge clk);
      end
      @(posedge clk);
      #1 line_out = 1'b1;
    end
  endtask

  // Short low pulse that is no valid start bit
  task automatic glitch(input int len);
    begin
      @(posedge clk);
      #1 line_out = 1'b0;
      repeat (len) @(posedge clk);
      #1 line_out = 1'b1;
    end
  endtask

  // Capture frames from the design, sampling each bit in its middle
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge clk);
    w = '0;
    for (int i = 0; i < nbits + par_en; i++) begin
      repeat (BIT) @(posedge clk);
      w[i] = line_in;
    end
    repeat (BIT) @(posedge clk);
    got_q.push_back(w);
  end
endmodule

// File: verification/usart_tx_rx_datapath_tb_top.sv
// Self-checking bench for the USART data path with a serial partner model.
// Assumes divisor 0, so every clock is a sample tick and a bit lasts 16 clocks.
`timescale 1ns/1ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("ERROR %0t: got %0h expected %0h", $time, got, exp); end end

module usart_tx_rx_datapath_tb_top;
  import usart_pkg::*;
  logic       clk, reset_n, ten, ren, nin, bie, tcie, wr, rd, tclr, tack, sin;
  logic       so, soe, sown, bef, tcf, rcf, bei, tci, line, xck;
  logic [7:0] wd;
  logic [3:0] nb;
  logic [3:0] xdiv;
  frame_cfg_s cfg;
  rx_word_s   rw;
  int         n_errors, samples_checked;

  // Released pin is pulled up
  assign line = soe ? so : 1'b1;

  // External serial clock of 16 clocks a period; stands still unless sync mode is chosen
  assign #1 xck = cfg.sync_mode && xdiv[3];
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) xdiv <= 4'h0;
    else xdiv <= xdiv + 4'h1;
  end

  usart_tx_rx_datapath i_usart_tx_rx_datapath (.clk(clk), .reset_n(reset_n), .frame_cfg(cfg),
    .baud_divisor(12'h000), .transmitter_enable(ten), .receiver_enable(ren), .transmit_ninth_bit(nin),
    .buffer_empty_irq_enable(bie), .transmit_complete_irq_enable(tcie), .data_wr(wr), .data_wdata(wd),
    .data_rd(rd), .txc_clear(tclr), .txc_irq_ack(tack), .serial_in_pin(sin), .serial_clock_pin(xck),
    .serial_out_pin_o(so), .serial_out_pin_oe(soe), .serial_in_owned(sown), .buffer_empty_flag(bef),
    .transmit_complete_flag(tcf), .receive_complete_flag(rcf), .rx_word(rw), .buffer_empty_irq(bei),
    .transmit_complete_irq(tci));

  usart_partner_model i_partner (.clk(clk), .line_in(line), .nbits(nb), .par_en(cfg.parity_enable_bit),
    .line_out(sin));

  // Clock of 25 ns
  always #12.5 clk = ~clk;

  task automatic summarize;
    begin
      if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  task automatic step;
    begin
      @(posedge clk);
      #1;
    end
  endtask

  // Frame format with odd parity selection
  task automatic setcfg(input logic [2:0] sz, input logic pe, input logic two);
    begin
      cfg = frame_cfg_s'({2'b00, sz, pe, 1'b1, two});
      nb = (sz == 3'h7) ? 4'h9 : 4'h5 + 4'(sz);
    end
  endtask

  task automatic wr_char(input logic [7:0] d);
    begin
      step;
      wd = d;
      wr = 1'b1;
      step;
      wr = 1'b0;
    end
  endtask

  // One-cycle pulse: 0 status write (one to complete bit, zero to empty bit), 1 service, 2 read
  task automatic pulse(input int sel);
    begin
      step;
      tclr = (sel == 0);
      tack = (sel == 1);
      rd = (sel == 2);
      step;
      {tclr, tack, rd} = 3'b000;
    end
  endtask

  // Bounded wait: 0 complete, 1 received, 2 pin released, 3 buffer empty, 4 partner frames, 5 clock phase
  task automatic wait_on(input int which, input int n);
    int i;
    begin
      for (i = 0; i < 4000; i++) begin
        if ((which == 0 && tcf === 1'b1) || (which == 1 && rcf === 1'b1) || (which == 2 && soe === 1'b0) ||
            (which == 3 && bef === 1'b1) || (which == 4 && i_partner.got_q.size() >= n) ||
            (which == 5 && xdiv == 4'(n))) break;
        step;
      end
      if (i == 4000) begin
        n_errors++;
        summarize;
      end
    end
  endtask

  task automatic rd_word(input logic [11:0] e);
    begin
      wait_on(1, 0);
      `CHECK(rw, e)
      pulse(2);
    end
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {ten, ren, nin, bie, tcie, wr, rd, tclr, tack} = '0;
    wd = 8'h00;
    n_errors = 0;
    samples_checked = 0;
    setcfg(3'h3, 1'b0, 1'b0);
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    `CHECK(bef, 1'b1)
    `CHECK(soe, 1'b0)
    `CHECK(tcf, 1'b0)
    ten = 1'b1;
    bie = 1'b1;
    tcie = 1'b1;
    step;
    step;
    `CHECK(soe, 1'b1)
    `CHECK(bei, 1'b1)
    // Plain 8N1 character and completion
    wr_char(8'hA5);
    `CHECK(bef, 1'b0)
    `CHECK(bei, 1'b0)
    wait_on(4, 1);
    `CHECK(i_partner.got_q[0], 10'h0A5)
    `CHECK(tcf, 1'b0)
    wait_on(0, 0);
    `CHECK(tci, 1'b1)
    pulse(1);
    `CHECK(tcf, 1'b0)
    // Pending character overwritten while the shifter is busy
    wr_char(8'h11);
    wait_on(3, 0);
    wr_char(8'h22);
    wr_char(8'h33);
    wait_on(4, 3);
    `CHECK(i_partner.got_q[1], 10'h011)
    `CHECK(i_partner.got_q[2], 10'h033)
    wait_on(0, 0);
    pulse(0);
    `CHECK(tcf, 1'b0)
    `CHECK(tci, 1'b0)
    // Seven bits with odd parity: top bit dropped, parity after data
    setcfg(3'h2, 1'b1, 1'b0);
    wr_char(8'hFF);
    wait_on(4, 4);
    `CHECK(i_partner.got_q[3], 10'h07F)
    // Nine bits: ninth bit set before the low byte is written
    setcfg(3'h7, 1'b0, 1'b0);
    nin = 1'b1;
    wr_char(8'h3C);
    wait_on(4, 5);
    `CHECK(i_partner.got_q[4], 10'h13C)
    nin = 1'b0;
    // Disable in mid frame waits for the frame to finish
    setcfg(3'h3, 1'b0, 1'b0);
    wr_char(8'h96);
    ten = 1'b0;
    repeat (40) step;
    `CHECK(soe, 1'b1)
    wait_on(2, 0);
    `CHECK(i_partner.got_q.size(), 6)
    `CHECK(i_partner.got_q[5], 10'h096)
    // Reception
    ren = 1'b1;
    step;
    `CHECK(sown, 1'b1)
    i_partner.send(9'h05A, 1'b0, 1'b1);
    rd_word(12'h05A);
    `CHECK(rcf, 1'b0)
    i_partner.glitch(4);
    repeat (300) step;
    `CHECK(rcf, 1'b0)
    i_partner.send(9'h033, 1'b0, 1'b0);
    rd_word(12'h433);
    setcfg(3'h0, 1'b0, 1'b0);
    i_partner.send(9'h1FF, 1'b0, 1'b1);
    rd_word(12'h01F);
    // Six bits with a wrong odd parity bit: error stored with the character
    setcfg(3'h1, 1'b1, 1'b0);
    i_partner.send(9'h02A, 1'b1, 1'b1);
    rd_word(12'h22A);
    // Second stop bit configured but absent between frames
    setcfg(3'h3, 1'b0, 1'b1);
    i_partner.send(9'h0C3, 1'b0, 1'b1);
    i_partner.send(9'h03C, 1'b0, 1'b1);
    rd_word(12'h0C3);
    rd_word(12'h03C);
    // Four frames unread: third is lost, fourth carries the overrun mark
    for (int k = 1; k <= 4; k++) i_partner.send(9'(k), 1'b0, 1'b1);
    rd_word(12'h001);
    rd_word(12'h002);
    rd_word(12'h804);
    step;
    `CHECK(rcf, 1'b0)
    // Sync slave mode: data changes on rising, is sampled on falling external clock
    ten = 1'b1;
    setcfg(3'h3, 1'b0, 1'b0);
    cfg.sync_mode = 1'b1;
    wait_on(5, 9);
    wr_char(8'h5C);
    wait_on(4, 7);
    `CHECK(i_partner.got_q[6], 10'h05C)
    wait_on(5, 8);
    i_partner.send(9'h0A3, 1'b0, 1'b1);
    rd_word(12'h0A3);
    summarize;
  end
endmodule
